// [core/mucr_top.sv]
// Memory unit control register with speculation, watchpoint and translation controls
`include "mucr_regs.svh"
`default_nettype none
// How it works
// R1 - Bits 49:48 and 47:42 always read zero and writes to them are dropped.
// R2 - Bits 1 and 0 always read zero and writes to them are dropped.
// R3 - With bit 41 set, branch prediction is off and fetch treats every branch as not taken.
// R4 - With bit 41 set, loads and stores behind an unresolved branch are held.
// R5 - With bit 41 set, the hardware prefetcher is off and software prefetches do nothing.
// R6 - With bit 41 set, fetch past a control transfer is capped at 1KB.
// R7 - Software should issue a full barrier right after setting bit 41.
// R8 - Bits 32:25 hold a writable byte mask for the one shared watchpoint address.
// R9 - Bits 24 and 23 arm physical watchpoint exceptions for reads and writes.
// R10 - Bits 22 and 21 arm virtual watchpoint exceptions for reads and writes.
// R11 - With bit 3 clear, data addresses bypass translation and the virtual address is used.
// R12 - With bit 2 clear, instruction addresses bypass translation likewise.
// R13 - Software must flush after storing a new instruction translation enable.
// R14 - A match under both interpretations raises only the virtual exception.
// R15 - Physical comparison ignores watch address bits 63 to 41.
module mucr_top
    import mucr_pkg::*;
#(
    parameter logic [10:0] FETCH_AHEAD_MAX = 11'h7ff
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic asi_valid,
    input wire logic asi_write,
    input wire logic [7:0] asi_num,
    input wire logic [63:0] asi_va,
    input wire logic [63:0] asi_wdata,
    output logic [63:0] asi_rdata,
    output logic asi_rvalid,
    output logic asi_hit,
    input wire logic branch_pending,
    output logic branch_predict_off,
    output logic mem_op_hold,
    output logic hw_prefetch_off,
    output logic sw_prefetch_nop,
    output logic [10:0] fetch_limit_bytes,
    input wire logic dacc_valid,
    input wire logic dacc_write,
    input wire logic [63:0] dacc_va,
    input wire logic [7:0] dacc_bytes,
    input wire logic [63:0] dacc_tlb_pa,
    input wire logic [63:3] watch_address,
    output logic [63:0] data_pa,
    output logic virt_watch_exception,
    output logic phys_watch_exception,
    input wire logic [63:0] inst_va,
    input wire logic [63:0] inst_tlb_pa,
    output logic [63:0] inst_pa
);
    // A cap below the inhibited limit would make the inhibit widen fetch-ahead
    if (FETCH_AHEAD_MAX < `MUCR_SPEC_FETCH_LIMIT) begin : g_limit_check
        $error("FETCH_AHEAD_MAX below the inhibited fetch limit");
    end

    mucr_if bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // Register access in the control space
    logic [63:0] ctrl_word;
    logic [63:0] next_ctrl_word;
    logic [63:0] next_rdata;
    logic next_rvalid;
    logic next_hit;
    logic sel;

    always_comb begin
        sel = asi_valid && (asi_num == `MUCR_SPACE) && (asi_va == `MUCR_OFFSET);
        next_ctrl_word = ctrl_word;
        // R1 R2 R8 only writable bits stored
        if (sel && asi_write) begin
            next_ctrl_word = asi_wdata & `MUCR_RW_MASK;
        end
        next_rvalid = asi_valid && !asi_write;
        next_hit = sel;
        // Unmapped reads answer zero so stale data never leaks out
        next_rdata = (sel && !asi_write) ? (ctrl_word & `MUCR_RW_MASK) : 64'h0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_word <= `MUCR_RESET;
            asi_rdata <= 64'h0;
            asi_rvalid <= 1'b0;
            asi_hit <= 1'b0;
        end else begin
            ctrl_word <= next_ctrl_word;
            asi_rdata <= next_rdata;
            asi_rvalid <= next_rvalid;
            asi_hit <= next_hit;
        end
    end

    always_comb begin
        bus.ctrl.spec_inhibit = ctrl_word[`MUCR_SPEC_BIT];
        bus.ctrl.watch_mask = ctrl_word[`MUCR_MASK_HI:`MUCR_MASK_LO];
        bus.ctrl.phys_read_watch_en = ctrl_word[`MUCR_PR_BIT];
        bus.ctrl.phys_write_watch_en = ctrl_word[`MUCR_PW_BIT];
        bus.ctrl.virt_read_watch_en = ctrl_word[`MUCR_VR_BIT];
        bus.ctrl.virt_write_watch_en = ctrl_word[`MUCR_VW_BIT];
        bus.ctrl.data_translate_en = ctrl_word[`MUCR_DM_BIT];
        bus.ctrl.instr_translate_en = ctrl_word[`MUCR_IM_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Speculation controls
    logic next_predict_off;
    logic next_mem_hold;
    logic next_hw_pf_off;
    logic next_sw_pf_nop;
    logic [10:0] next_fetch_limit;

    always_comb begin
        // R3 no prediction
        next_predict_off = bus.ctrl.spec_inhibit;
        // R4 hold behind branch
        next_mem_hold = bus.ctrl.spec_inhibit && branch_pending;
        // R5 prefetch off
        next_hw_pf_off = bus.ctrl.spec_inhibit;
        next_sw_pf_nop = bus.ctrl.spec_inhibit;
        // R6 fetch cap
        next_fetch_limit = bus.ctrl.spec_inhibit ? `MUCR_SPEC_FETCH_LIMIT : FETCH_AHEAD_MAX;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            branch_predict_off <= 1'b0;
            mem_op_hold <= 1'b0;
            hw_prefetch_off <= 1'b0;
            sw_prefetch_nop <= 1'b0;
            fetch_limit_bytes <= FETCH_AHEAD_MAX;
        end else begin
            branch_predict_off <= next_predict_off;
            mem_op_hold <= next_mem_hold;
            hw_prefetch_off <= next_hw_pf_off;
            sw_prefetch_nop <= next_sw_pf_nop;
            fetch_limit_bytes <= next_fetch_limit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address translation bypass
    logic [63:0] next_data_pa;
    logic [63:0] next_inst_pa;

    always_comb begin
        // R11 data bypass
        next_data_pa = bus.ctrl.data_translate_en ? dacc_tlb_pa : dacc_va;
        // R12 instruction bypass
        next_inst_pa = bus.ctrl.instr_translate_en ? inst_tlb_pa : inst_va;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_pa <= 64'h0;
            inst_pa <= 64'h0;
        end else begin
            data_pa <= next_data_pa;
            inst_pa <= next_inst_pa;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchpoint matching; physical compare sees the same address that leaves the block
    assign bus.acc_valid = dacc_valid;
    assign bus.acc_write = dacc_write;
    assign bus.acc_va = dacc_va;
    assign bus.acc_pa = next_data_pa;
    assign bus.acc_bytes = dacc_bytes;
    assign bus.watch_address = watch_address;

    mucr_watch u_watch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(bus)
    );

    assign virt_watch_exception = bus.virt_hit;
    assign phys_watch_exception = bus.phys_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_write;
        sel && asi_write;
    endsequence
    sequence s_ctrl_read;
        sel && !asi_write;
    endsequence

    a_reserved_zero: assert property (s_ctrl_read |=> asi_rvalid && asi_rdata[49:42] == 8'h00) // R1
        else $error("reserved bits read nonzero");
    a_unused_zero: assert property (s_ctrl_read |=> asi_rdata[1:0] == 2'h0) // R2
        else $error("unused cache enables read nonzero");
    a_mask_readback: assert property (s_ctrl_write ##1 s_ctrl_read |=>
        asi_rdata[32:25] == $past(asi_wdata[32:25], 2)) // R8
        else $error("watch mask not stored");
    a_predict_off: assert property ((s_ctrl_write and asi_wdata[41]) |=> ##1 branch_predict_off) // R3
        else $error("prediction still on after inhibit");
    a_mem_hold: assert property (bus.ctrl.spec_inhibit && branch_pending |=> mem_op_hold) // R4
        else $error("memory op not held behind branch");
    a_prefetch_off: assert property (bus.ctrl.spec_inhibit |=> hw_prefetch_off && sw_prefetch_nop) // R5
        else $error("prefetch active while inhibited");
    a_fetch_limit: assert property (bus.ctrl.spec_inhibit |=> fetch_limit_bytes <= 11'h400) // R6
        else $error("fetch-ahead over limit");
    a_data_bypass: assert property (!bus.ctrl.data_translate_en |=> data_pa == $past(dacc_va)) // R11
        else $error("data address translated while disabled");
    a_instr_bypass: assert property (!bus.ctrl.instr_translate_en |=> inst_pa == $past(inst_va)) // R12
        else $error("instruction address translated while disabled");
endmodule
`default_nettype wire

// [shared/mucr_regs.svh]
// Offsets, field positions, reset values and limits of the memory unit control register
`ifndef MUCR_REGS_SVH
`define MUCR_REGS_SVH
`define MUCR_SPACE 8'h45
`define MUCR_OFFSET 64'h0000_0000_0000_0000
`define MUCR_RESET 64'h0000_0000_0000_0000
`define MUCR_RW_MASK 64'h0000_0201_ffe0_000c
`define MUCR_SPEC_BIT 41
`define MUCR_MASK_HI 32
`define MUCR_MASK_LO 25
`define MUCR_PR_BIT 24
`define MUCR_PW_BIT 23
`define MUCR_VR_BIT 22
`define MUCR_VW_BIT 21
`define MUCR_DM_BIT 3
`define MUCR_IM_BIT 2
`define MUCR_PHYS_TOP 40
`define MUCR_SPEC_FETCH_LIMIT 11'h400
`endif

// [shared/mucr_pkg.sv]
// Types shared by the memory unit control register and its watchpoint matcher
`default_nettype none
package mucr_pkg;
    typedef struct packed {
        logic spec_inhibit;
        logic [7:0] watch_mask;
        logic phys_read_watch_en;
        logic phys_write_watch_en;
        logic virt_read_watch_en;
        logic virt_write_watch_en;
        logic data_translate_en;
        logic instr_translate_en;
    } mucr_ctrl_t;
endpackage
`default_nettype wire

// [shared/mucr_if.sv]
// Carrier between the control register and the watchpoint matcher
`default_nettype none
interface mucr_if;
    import mucr_pkg::*;
    mucr_ctrl_t ctrl;
    logic acc_valid;
    logic acc_write;
    logic [63:0] acc_va;
    logic [63:0] acc_pa;
    logic [7:0] acc_bytes;
    logic [63:3] watch_address;
    logic virt_hit;
    logic phys_hit;
    modport regs (output ctrl, acc_valid, acc_write, acc_va, acc_pa, acc_bytes, watch_address,
        input virt_hit, phys_hit);
    modport watch (input ctrl, acc_valid, acc_write, acc_va, acc_pa, acc_bytes, watch_address,
        output virt_hit, phys_hit);
endinterface
`default_nettype wire

// [core/mucr_watch.sv]
// Data watchpoint matcher for virtual and physical interpretations of one address
`include "mucr_regs.svh"
`default_nettype none
module mucr_watch
    import mucr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    mucr_if.watch bus
);
    logic virt_hit;
    logic phys_hit;
    logic next_virt_hit;
    logic next_phys_hit;
    logic virt_match;
    logic phys_match;
    logic lanes_hit;
    logic rd_armed_v;
    logic rd_armed_p;

    always_comb begin
        // Byte mask selects which bytes of the watched doubleword trigger
        lanes_hit = |(bus.ctrl.watch_mask & bus.acc_bytes);
        virt_match = bus.acc_valid && lanes_hit && (bus.acc_va[63:3] == bus.watch_address);
        // R15 high bits ignored
        phys_match = bus.acc_valid && lanes_hit &&
            (bus.acc_pa[`MUCR_PHYS_TOP:3] == bus.watch_address[`MUCR_PHYS_TOP:3]);
        // R10 virtual enables
        rd_armed_v = bus.acc_write ? bus.ctrl.virt_write_watch_en : bus.ctrl.virt_read_watch_en;
        // R9 physical enables
        rd_armed_p = bus.acc_write ? bus.ctrl.phys_write_watch_en : bus.ctrl.phys_read_watch_en;
        next_virt_hit = virt_match && rd_armed_v;
        // R14 virtual wins
        next_phys_hit = phys_match && rd_armed_p && !next_virt_hit;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            virt_hit <= 1'b0;
            phys_hit <= 1'b0;
        end else begin
            virt_hit <= next_virt_hit;
            phys_hit <= next_phys_hit;
        end
    end

    assign bus.virt_hit = virt_hit;
    assign bus.phys_hit = phys_hit;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_virt_priority: assert property (!(virt_hit && phys_hit)) // R14
        else $error("both watchpoint exceptions raised together");
    a_phys_read_hit: assert property (phys_match && !bus.acc_write && bus.ctrl.phys_read_watch_en
        && !next_virt_hit |=> phys_hit) // R9
        else $error("physical read watchpoint missed");
    a_virt_write_hit: assert property (virt_match && bus.acc_write && bus.ctrl.virt_write_watch_en
        |=> virt_hit) // R10
        else $error("virtual write watchpoint missed");
    a_phys_disabled: assert property (!bus.ctrl.phys_read_watch_en && !bus.ctrl.phys_write_watch_en
        |=> !phys_hit) // R9
        else $error("physical watchpoint without enable");
    a_phys_high_ignored: assert property (bus.acc_valid && lanes_hit && !bus.acc_write &&
        bus.ctrl.phys_read_watch_en && !bus.ctrl.virt_read_watch_en &&
        bus.acc_pa[`MUCR_PHYS_TOP:3] == bus.watch_address[`MUCR_PHYS_TOP:3] |=> phys_hit) // R15
        else $error("physical compare looked at high address bits");
endmodule
`default_nettype wire

// [bench/mucr_tb.sv]
// Self-checking testbench for the memory unit control register
`include "mucr_regs.svh"
`default_nettype none
module testbench;
timeunit 1ns;
timeprecision 1ps;
import mucr_pkg::*;
// Differs from the inhibited limit so both settings can be told apart
localparam logic [10:0] FA_MAX = 11'h600;
localparam logic [63:0] WA = 64'h0055_0000_0000_1000;
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic asi_valid = 1'b0;
logic asi_write = 1'b0;
logic [7:0] asi_num = 8'h00;
logic [63:0] asi_va = 64'h0;
logic [63:0] asi_wdata = 64'h0;
logic [63:0] asi_rdata;
logic asi_rvalid;
logic asi_hit;
logic branch_pending = 1'b0;
logic branch_predict_off;
logic mem_op_hold;
logic hw_prefetch_off;
logic sw_prefetch_nop;
logic [10:0] fetch_limit_bytes;
logic dacc_valid = 1'b0;
logic dacc_write = 1'b0;
logic [63:0] dacc_va = 64'h0;
logic [7:0] dacc_bytes = 8'h00;
logic [63:0] dacc_tlb_pa = 64'h0;
logic [63:3] watch_address = 61'h0;
logic [63:0] data_pa;
logic virt_watch_exception;
logic phys_watch_exception;
logic [63:0] inst_va = 64'h0;
logic [63:0] inst_tlb_pa = 64'h0;
logic [63:0] inst_pa;
int mismatches = 0;
int num_checks = 0;
logic [63:0] rd;
logic [63:0] dp;
logic [63:0] ip;
logic hit;
logic rv;

always #25 clk_sys = ~clk_sys;

mucr_top #(.FETCH_AHEAD_MAX(FA_MAX)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .asi_valid(asi_valid),
    .asi_write(asi_write), .asi_num(asi_num), .asi_va(asi_va), .asi_wdata(asi_wdata), .asi_rdata(asi_rdata),
    .asi_rvalid(asi_rvalid), .asi_hit(asi_hit), .branch_pending(branch_pending),
    .branch_predict_off(branch_predict_off), .mem_op_hold(mem_op_hold), .hw_prefetch_off(hw_prefetch_off),
    .sw_prefetch_nop(sw_prefetch_nop), .fetch_limit_bytes(fetch_limit_bytes), .dacc_valid(dacc_valid),
    .dacc_write(dacc_write), .dacc_va(dacc_va), .dacc_bytes(dacc_bytes), .dacc_tlb_pa(dacc_tlb_pa),
    .watch_address(watch_address), .data_pa(data_pa), .virt_watch_exception(virt_watch_exception),
    .phys_watch_exception(phys_watch_exception), .inst_va(inst_va), .inst_tlb_pa(inst_tlb_pa),
    .inst_pa(inst_pa));

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
endtask

// One register-space access; answer is sampled mid-cycle after the taking edge
task automatic acc(input logic wr, input logic [7:0] num, input logic [63:0] va, input logic [63:0] wd);
    @(posedge clk_sys);
    asi_valid <= 1'b1;
    asi_write <= wr;
    asi_num <= num;
    asi_va <= va;
    asi_wdata <= wd;
    @(posedge clk_sys);
    asi_valid <= 1'b0;
    @(negedge clk_sys);
    rd = asi_rdata;
    hit = asi_hit;
    rv = asi_rvalid;
endtask

// One data access, also presenting the same addresses to the fetch side
task automatic dacc(input logic wr, input logic [63:0] va, input logic [63:0] pa, input logic [7:0] by,
    input logic ev, input logic ep);
    @(posedge clk_sys);
    dacc_valid <= 1'b1;
    dacc_write <= wr;
    dacc_va <= va;
    dacc_tlb_pa <= pa;
    dacc_bytes <= by;
    inst_va <= va;
    inst_tlb_pa <= pa;
    @(posedge clk_sys);
    dacc_valid <= 1'b0;
    @(negedge clk_sys);
    dp = data_pa;
    ip = inst_pa;
    chk("virt_watch_exception", {63'h0, ev}, {63'h0, virt_watch_exception});
    chk("phys_watch_exception", {63'h0, ep}, {63'h0, phys_watch_exception});
endtask

task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask

// Watchdog so a stuck run still reaches the verdict
initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    finish_test();
end

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    acc(1'b0, `MUCR_SPACE, 64'h0, 64'h0);
    chk("reset value", `MUCR_RESET, rd);
    chk("fetch_limit_bytes", {53'h0, FA_MAX}, {53'h0, fetch_limit_bytes});
    acc(1'b1, `MUCR_SPACE, 64'h0, '1);
    chk("store hit", 64'h1, {63'h0, hit});
    acc(1'b0, `MUCR_SPACE, 64'h0, 64'h0);
    chk("readback ones", `MUCR_RW_MASK, rd);
    chk("load rvalid", 64'h1, {63'h0, rv});
    acc(1'b1, `MUCR_SPACE, 64'h0, ~`MUCR_RW_MASK);
    acc(1'b0, `MUCR_SPACE, 64'h0, 64'h0);
    chk("readback reserved", 64'h0, rd);
    // Unmapped space and offset must neither store nor hit, and a read there returns zero
    acc(1'b1, 8'h44, 64'h0, '1);
    acc(1'b1, `MUCR_SPACE, 64'h8, '1);
    acc(1'b0, `MUCR_SPACE, 64'h8, 64'h0);
    chk("unmapped hit", 64'h0, {63'h0, hit});
    chk("unmapped rdata", 64'h0, rd);
    acc(1'b0, `MUCR_SPACE, 64'h0, 64'h0);
    chk("after unmapped", 64'h0, rd);
    $display("test registers done");

    acc(1'b1, `MUCR_SPACE, 64'h0, 64'h1 << `MUCR_SPEC_BIT);
    @(negedge clk_sys);
    chk("branch_predict_off", 64'h1, {63'h0, branch_predict_off});
    chk("hw_prefetch_off", 64'h1, {63'h0, hw_prefetch_off});
    chk("sw_prefetch_nop", 64'h1, {63'h0, sw_prefetch_nop});
    chk("fetch_limit_bytes", {53'h0, `MUCR_SPEC_FETCH_LIMIT}, {53'h0, fetch_limit_bytes});
    chk("mem_op_hold idle", 64'h0, {63'h0, mem_op_hold});
    @(posedge clk_sys);
    branch_pending <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("mem_op_hold", 64'h1, {63'h0, mem_op_hold});
    acc(1'b1, `MUCR_SPACE, 64'h0, 64'h0);
    @(negedge clk_sys);
    chk("mem_op_hold off", 64'h0, {63'h0, mem_op_hold});
    chk("predict on", 64'h0, {63'h0, branch_predict_off});
    chk("limit back", {53'h0, FA_MAX}, {53'h0, fetch_limit_bytes});
    @(posedge clk_sys);
    branch_pending <= 1'b0;
    $display("test speculation done");

    dacc(1'b0, 64'h1111_0000_0000_2000, 64'h2222_0000_0000_3000, 8'h01, 1'b0, 1'b0);
    chk("data_pa bypass", 64'h1111_0000_0000_2000, dp);
    chk("inst_pa bypass", 64'h1111_0000_0000_2000, ip);
    acc(1'b1, `MUCR_SPACE, 64'h0, (64'h1 << `MUCR_DM_BIT) | (64'h1 << `MUCR_IM_BIT));
    @(posedge clk_sys);
    dacc(1'b0, 64'h1111_0000_0000_2000, 64'h2222_0000_0000_3000, 8'h01, 1'b0, 1'b0);
    chk("data_pa mapped", 64'h2222_0000_0000_3000, dp);
    chk("inst_pa mapped", 64'h2222_0000_0000_3000, ip);
    $display("test translation done");

    @(posedge clk_sys);
    watch_address <= WA[63:3];
    acc(1'b1, `MUCR_SPACE, 64'h0, (64'hff << `MUCR_MASK_LO) | (64'h1 << `MUCR_PR_BIT) |
        (64'h1 << `MUCR_VR_BIT) | (64'h1 << `MUCR_DM_BIT));
    dacc(1'b0, WA, WA, 8'h01, 1'b1, 1'b0);
    dacc(1'b0, WA + 64'h8, WA ^ 64'h8000_0000_0000_0000, 8'h01, 1'b0, 1'b1);
    dacc(1'b1, WA, WA, 8'h01, 1'b0, 1'b0);
    acc(1'b1, `MUCR_SPACE, 64'h0, (64'h0f << `MUCR_MASK_LO) | (64'h1 << `MUCR_PW_BIT) |
        (64'h1 << `MUCR_VW_BIT) | (64'h1 << `MUCR_DM_BIT));
    dacc(1'b1, WA, WA + 64'h8, 8'hf0, 1'b0, 1'b0);
    dacc(1'b1, WA, WA + 64'h8, 8'h08, 1'b1, 1'b0);
    dacc(1'b1, WA + 64'h8, WA, 8'h08, 1'b0, 1'b1);
    dacc(1'b0, WA, WA, 8'h08, 1'b0, 1'b0);
    $display("test watchpoint done");
    finish_test();
end
endmodule
`default_nettype wire
